//--- design/scc_converter_control.sv
// Converter control: channel mux, pin override, result and completion
`timescale 1ns/1ps
// Overview of operation
// R1: One of eight channel pins, picked by the channel field, feeds the converter.
// R2: At conversion end the 10-bit result is stored, then flag or interrupt.
// R3: The selected pin is forced to be a converter input, not a port pin.
// R4: Unselected channel pins stay ordinary general-purpose port pins.
// R5: Port output and direction writes leave the selected pin untouched.
// R6: A port read returns 0 for the selected pin's bit; the code clears that bit one clock after the selection changes.
// R7: With interrupts off the read-only done flag sets at every conversion end.
// R8: The done flag holds until a result read or a control write that enables interrupts; reset clears it.
// R9: With interrupts on the done flag never sets and reads as 0.
// R10: With interrupts on an interrupt request rises at every conversion end.
// R11: A result read or a control write drops the pending interrupt request.
// R12: Reset clears the interrupt enable, so completion is polled after reset.
// R13: Software picks single or continuous conversion.
// R14: Result is right, left, or left-justified signed within two bytes.
// R15: Continuous mode restarts at once and overwrites the result each time.
// R16: Software starts a conversion by writing the control settings.
module scc_converter_control
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ctrl_wr,
    input wire logic [SCC_CHAN_W-1:0] ctrl_chan,
    input wire logic ctrl_continuous,
    input wire logic ctrl_irq_enable,
    input wire logic ctrl_on,
    input wire logic [1:0] ctrl_justify,
    input wire logic clk_wr,
    input wire logic [SCC_DIV_W-1:0] clk_div,
    input wire logic result_rd,
    input wire logic cmp_high,
    input wire logic port_out_wr,
    input wire logic [SCC_CHANNELS-1:0] port_out_data,
    input wire logic port_dir_wr,
    input wire logic [SCC_CHANNELS-1:0] port_dir_data,
    input wire logic [SCC_CHANNELS-1:0] pin_in,
    output logic [SCC_CHANNELS-1:0] pin_out,
    output logic [SCC_CHANNELS-1:0] pin_oe_n,
    output logic [SCC_CHANNELS-1:0] port_rd_data,
    output logic [SCC_CHANNELS-1:0] selected_analog_input,
    output logic [SCC_RES_W-1:0] dac_code,
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte,
    output logic conversion_done_flag,
    output logic conversion_irq_enable,
    output logic conversion_irq,
    output logic converter_busy
);
    function automatic logic [15:0] scc_place(input logic [SCC_RES_W-1:0] r,
                                              input scc_just_t j);
        logic [15:0] v;
        v = {6'h00, r};
        unique case (j)
            SCC_JUST_LEFT: v = {r, 6'h00};
            SCC_JUST_LEFT_SIGNED:
                v = {~r[SCC_RES_W-1], r[SCC_RES_W-2:0], 6'h00};
            default: v = {6'h00, r};
        endcase
        return v;
    endfunction

    // Port bits of the selected pin keep their old value
    function automatic logic [SCC_CHANNELS-1:0] scc_keep(
        input logic [SCC_CHANNELS-1:0] wr_data,
        input logic [SCC_CHANNELS-1:0] old_data,
        input logic [SCC_CHANNELS-1:0] keep_mask);
        return (wr_data & ~keep_mask) | (old_data & keep_mask);
    endfunction

    logic [SCC_CHAN_W-1:0] chan_reg, chan_next;
    logic cont_reg, cont_next;
    logic ien_reg, ien_next;
    logic on_reg, on_next;
    scc_just_t just_reg, just_next;
    logic [SCC_DIV_W-1:0] div_reg, div_next;
    logic [SCC_PRE_W-1:0] pre_reg, pre_next;
    logic [7:0] hi_reg, hi_next, lo_reg, lo_next;
    logic flag_reg, flag_next;
    logic irq_reg, irq_next;
    logic [SCC_CHANNELS-1:0] pout_reg, pout_next, pdir_reg, pdir_next;
    logic [SCC_CHANNELS-1:0] prd_reg, prd_next;
    logic [SCC_CHANNELS-1:0] sel_mask;
    logic [15:0] placed;
    logic tick, sar_start, sar_done, sar_busy;
    logic [SCC_RES_W-1:0] code_out;

    // Converter clock: divide by 1, 2, 4 or 8 from the bus clock
    assign tick = ((pre_reg & ((SCC_PRE_W'(1) << div_reg) - 1'b1)) == '0);
    assign sar_start = ctrl_wr | (cont_reg & on_reg & sar_done); // [R16] [R13] [R15]
    // Override only while the converter is switched on
    assign sel_mask = on_reg ? (SCC_CHANNELS'(1) << chan_reg) : '0; // [R1] [R3]
    assign placed = scc_place(code_out, just_reg); // [R14]

    scc_sar_engine u_sar (
        .clk(clk),
        .rstn(rstn),
        .start(sar_start),
        .tick(tick),
        .cmp_high(cmp_high),
        .dac_code(code_out),
        .busy(sar_busy),
        .done(sar_done)
    );

    // Configuration group
    always_comb begin
        chan_next = chan_reg;
        cont_next = cont_reg;
        ien_next = ien_reg;
        on_next = on_reg;
        just_next = just_reg;
        div_next = div_reg;
        pre_next = pre_reg + 1'b1;
        if (ctrl_wr) begin
            chan_next = ctrl_chan;
            cont_next = ctrl_continuous;
            ien_next = ctrl_irq_enable;
            on_next = ctrl_on;
            just_next = scc_just_t'(ctrl_justify);
            // Prescaler restart gives every software-started conversion the same length
            pre_next = SCC_PRE_RST;
        end
        if (clk_wr)
            div_next = clk_div;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chan_reg <= SCC_CHAN_RST;
            cont_reg <= 1'b0;
            ien_reg <= 1'b0; // [R12]
            on_reg <= 1'b0;
            just_reg <= SCC_JUST_RIGHT;
            div_reg <= SCC_DIV_RST;
            pre_reg <= SCC_PRE_RST;
        end else begin
            chan_reg <= chan_next;
            cont_reg <= cont_next;
            ien_reg <= ien_next;
            on_reg <= on_next;
            just_reg <= just_next;
            div_reg <= div_next;
            pre_reg <= pre_next;
        end
    end

    // Port group
    always_comb begin
        pout_next = pout_reg;
        pdir_next = pdir_reg;
        if (port_out_wr)
            pout_next = scc_keep(port_out_data, pout_reg, sel_mask); // [R5]
        if (port_dir_wr)
            pdir_next = scc_keep(port_dir_data, pdir_reg, sel_mask); // [R5]
        prd_next = pin_in & ~sel_mask; // [R6] [R4]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pout_reg <= '0;
            pdir_reg <= '0;
            prd_reg <= '0;
        end else begin
            pout_reg <= pout_next;
            pdir_reg <= pdir_next;
            prd_reg <= prd_next;
        end
    end

    // Result and completion group
    always_comb begin
        hi_next = hi_reg;
        lo_next = lo_reg;
        flag_next = flag_reg;
        irq_next = irq_reg;
        // Clears first, so a completion in the same cycle wins
        if (result_rd)
            flag_next = 1'b0; // [R8]
        if (result_rd || ctrl_wr)
            irq_next = 1'b0; // [R11]
        if (sar_done) begin
            {hi_next, lo_next} = placed; // [R2] [R15]
            if (ien_reg)
                irq_next = 1'b1; // [R10]
            else
                flag_next = 1'b1; // [R7]
        end
        // Enabling interrupts discards a flag set in the same cycle
        if (ien_next)
            flag_next = 1'b0; // [R9]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_reg <= SCC_BYTE_RST;
            lo_reg <= SCC_BYTE_RST;
            flag_reg <= 1'b0; // [R8]
            irq_reg <= 1'b0;
        end else begin
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            flag_reg <= flag_next;
            irq_reg <= irq_next;
        end
    end

    assign pin_out = pout_reg & ~sel_mask;
    assign pin_oe_n = ~(pdir_reg & ~sel_mask); // [R3] [R4]
    assign port_rd_data = prd_reg;
    assign selected_analog_input = sel_mask; // [R1]
    assign dac_code = code_out;
    assign result_high_byte = hi_reg;
    assign result_low_byte = lo_reg;
    assign conversion_done_flag = flag_reg & ~ien_reg; // [R9]
    assign conversion_irq_enable = ien_reg;
    assign conversion_irq = irq_reg;
    assign converter_busy = sar_busy;
endmodule // scc_converter_control

//--- shared/scc_pkg.sv
// Constants and types shared by the converter control block
package scc_pkg;
    localparam int SCC_CHANNELS = 8;
    localparam int SCC_CHAN_W = 3;
    localparam int SCC_RES_W = 10;
    localparam int SCC_BIT_W = 4;
    localparam int SCC_DIV_W = 2;
    localparam int SCC_PRE_W = 3;
    localparam logic [SCC_BIT_W-1:0] SCC_MSB_IDX = 4'h9;
    localparam logic [SCC_BIT_W-1:0] SCC_LSB_IDX = 4'h0;
    localparam logic [SCC_RES_W-1:0] SCC_MSB_ONE = 10'h200;
    localparam logic [SCC_RES_W-1:0] SCC_CODE_RST = 10'h000;
    localparam logic [SCC_PRE_W-1:0] SCC_PRE_RST = 3'h0;
    localparam logic [7:0] SCC_BYTE_RST = 8'h00;
    localparam logic [SCC_CHAN_W-1:0] SCC_CHAN_RST = 3'h0;
    localparam logic [SCC_DIV_W-1:0] SCC_DIV_RST = 2'h0;

    // Placement of the result within the two result bytes
    typedef enum logic [1:0] {
        SCC_JUST_RIGHT = 2'h0,
        SCC_JUST_LEFT = 2'h1,
        SCC_JUST_LEFT_SIGNED = 2'h2,
        SCC_JUST_RSVD = 2'h3
    } scc_just_t;
endpackage

//--- design/scc_sar_engine.sv
// Successive approximation sequencer for one 10-bit conversion
`timescale 1ns/1ps
module scc_sar_engine
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic tick,
    input wire logic cmp_high,
    output logic [SCC_RES_W-1:0] dac_code,
    output logic busy,
    output logic done
);
    typedef enum logic [1:0] {SCC_IDLE, SCC_SAMPLE, SCC_CONVERT} scc_sar_t;

    scc_sar_t state_reg, state_next;
    logic [SCC_RES_W-1:0] code_reg, code_next;
    logic [SCC_BIT_W-1:0] bit_reg, bit_next;
    logic done_reg, done_next;

    always_comb begin
        state_next = state_reg;
        code_next = code_reg;
        bit_next = bit_reg;
        done_next = 1'b0;
        if (start) begin
            // A new start abandons any conversion under way
            state_next = SCC_SAMPLE;
            code_next = SCC_CODE_RST;
        end else if (tick) begin
            unique case (state_reg)
                SCC_IDLE: begin
                end
                SCC_SAMPLE: begin
                    state_next = SCC_CONVERT;
                    code_next = SCC_MSB_ONE;
                    bit_next = SCC_MSB_IDX;
                end
                SCC_CONVERT: begin
                    if (!cmp_high)
                        code_next[bit_reg] = 1'b0;
                    if (bit_reg == SCC_LSB_IDX) begin
                        state_next = SCC_IDLE;
                        done_next = 1'b1;
                    end else begin
                        bit_next = bit_reg - 1'b1;
                        code_next[bit_reg - 1'b1] = 1'b1;
                    end
                end
                default: state_next = SCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SCC_IDLE;
            code_reg <= SCC_CODE_RST;
            bit_reg <= SCC_LSB_IDX;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            code_reg <= code_next;
            bit_reg <= bit_next;
            done_reg <= done_next;
        end
    end

    assign dac_code = code_reg;
    assign busy = (state_reg != SCC_IDLE);
    assign done = done_reg;
endmodule // scc_sar_engine

//--- bench/scc_converter_control_monitor.sv
// Port checker for the converter control block
`timescale 1ns/1ps
module scc_converter_control_monitor
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ctrl_wr,
    input wire logic result_rd,
    input wire logic port_dir_wr,
    input wire logic [SCC_CHANNELS-1:0] port_dir_data,
    input wire logic [SCC_CHANNELS-1:0] pin_out,
    input wire logic [SCC_CHANNELS-1:0] pin_oe_n,
    input wire logic [SCC_CHANNELS-1:0] port_rd_data,
    input wire logic [SCC_CHANNELS-1:0] selected_analog_input,
    input wire logic conversion_done_flag,
    input wire logic conversion_irq_enable,
    input wire logic conversion_irq,
    input wire logic converter_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_flag_masked: assert property (conversion_irq_enable
        |-> !conversion_done_flag) else $error("flag set with irq on");
    a_flag_holds: assert property (conversion_done_flag
        && !result_rd && !ctrl_wr |=> conversion_done_flag)
        else $error("flag dropped without read");
    a_flag_cause: assert property ($rose(conversion_done_flag)
        |-> !conversion_irq_enable) else $error("flag rose with irq on");
    a_irq_cause: assert property (conversion_irq
        |-> conversion_irq_enable) else $error("irq without enable");
    // Busy guard: in continuous mode a new end may set it again
    a_irq_drop: assert property (ctrl_wr || (result_rd
        && !converter_busy) |=> !conversion_irq) else $error("irq held");
    a_sel_onehot: assert property (
        $onehot0(selected_analog_input)) else $error("mux not one-hot");
    a_sel_override: assert property ((
        selected_analog_input & (pin_out | ~pin_oe_n)) == 8'h00)
        else $error("selected pin driven");
    a_port_rd_zero: assert property ((port_rd_data
        & selected_analog_input & $past(selected_analog_input)) == 8'h00)
        else $error("selected bit read as 1");
    a_dir_follow: assert property (port_dir_wr && !ctrl_wr
        |=> (pin_oe_n | selected_analog_input)
        == (~$past(port_dir_data) | selected_analog_input))
        else $error("free pin direction wrong");
    cover property (ctrl_wr ##1 converter_busy);
    cover property ($rose(conversion_irq));
    cover property ($rose(conversion_done_flag) ##[1:40] result_rd);
endmodule // scc_converter_control_monitor

//--- bench/scc_analog_pins.sv
// Pins and comparator on the far side of the channel mux
`timescale 1ns/1ps
module scc_analog_pins
    import scc_pkg::*;
(
    input wire logic [SCC_CHANNELS-1:0] selected_analog_input,
    input wire logic [SCC_RES_W-1:0] dac_code,
    input wire logic [SCC_CHANNELS-1:0] pin_out,
    input wire logic [SCC_CHANNELS-1:0] pin_oe_n,
    input wire logic [SCC_CHANNELS-1:0] ext_level,
    output logic cmp_high,
    output logic [SCC_CHANNELS-1:0] pin_in
);
    logic [SCC_RES_W-1:0] lvl;
    // Fixed level per channel; no channel gives a zero input
    always_comb begin
        lvl = SCC_CODE_RST;
        for (int i = 0; i < SCC_CHANNELS; i++) begin
            if (selected_analog_input[i]) begin
                lvl = SCC_RES_W'(64 * i + 37);
            end
        end
        cmp_high = (lvl >= dac_code);
    end
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule // scc_analog_pins

//--- bench/tb_scc_converter_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_scc_converter_control;
    import scc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ctrl_wr = 1'b0;
    logic [2:0] ctrl_chan = 3'h0;
    logic ctrl_continuous = 1'b0;
    logic ctrl_irq_enable = 1'b0;
    logic [1:0] ctrl_justify = 2'h0;
    logic ctrl_on = 1'b1;
    logic clk_wr = 1'b0;
    logic [1:0] clk_div = 2'h0;
    logic result_rd = 1'b0;
    logic port_wr = 1'b0;
    logic [7:0] out_d = 8'h00;
    logic [7:0] dir_d = 8'h00;
    logic cmp_high;
    logic [7:0] pin_in, pin_out, pin_oe_n, rd_d, sel, rhi, rlo;
    logic [9:0] dac_code;
    logic flag, irq_en, irq;
    int error_cnt = 0;
    int checks_done = 0;
    always #25 clk = ~clk;
    scc_converter_control dut_u (.clk(clk), .rstn(rstn), .ctrl_wr(ctrl_wr),
        .ctrl_chan(ctrl_chan), .ctrl_continuous(ctrl_continuous),
        .ctrl_irq_enable(ctrl_irq_enable), .ctrl_on(ctrl_on),
        .ctrl_justify(ctrl_justify), .clk_wr(clk_wr), .clk_div(clk_div),
        .result_rd(result_rd), .cmp_high(cmp_high), .port_out_wr(port_wr),
        .port_out_data(out_d), .port_dir_wr(port_wr), .port_dir_data(dir_d),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .port_rd_data(rd_d), .selected_analog_input(sel),
        .dac_code(dac_code), .result_high_byte(rhi), .result_low_byte(rlo),
        .conversion_done_flag(flag), .conversion_irq_enable(irq_en),
        .conversion_irq(irq), .converter_busy());
    scc_analog_pins pins_u (.selected_analog_input(sel), .dac_code(dac_code),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(8'h7C),
        .cmp_high(cmp_high), .pin_in(pin_in));
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic ctl(input logic [2:0] ch, input logic c, input logic ie,
        input logic [1:0] j);
        @(negedge clk);
        ctrl_wr = 1'b1;
        ctrl_chan = ch;
        ctrl_continuous = c;
        ctrl_irq_enable = ie;
        ctrl_justify = j;
        @(negedge clk);
        ctrl_wr = 1'b0;
    endtask
    // Asynchronous reset in mid-run, released off the sampling edge
    task automatic reset_pulse;
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
    endtask
    task automatic rd;
        @(negedge clk);
        result_rd = 1'b1;
        @(negedge clk);
        result_rd = 1'b0;
    endtask
    // Bounded wait; a stuck conversion ends the run
    task automatic wait_for(input logic use_irq);
        int n;
        n = 0;
        while ((use_irq ? irq : flag) !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    function automatic logic [15:0] place(input int c, input logic [1:0] j);
        logic [9:0] r;
        r = 10'(64 * c + 37);
        case (j)
            2'h1: return {r, 6'h00};
            2'h2: return {~r[9], r[8:0], 6'h00};
            default: return {6'h00, r};
        endcase
    endfunction
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        chk({13'h0, flag, irq_en, irq}, 16'h0000);
        for (int j = 0; j < 4; j++) begin
            ctl(3'(j + 3), 1'b0, 1'b0, 2'(j));
            wait_for(1'b0);
            chk({rhi, rlo}, place(j + 3, 2'(j)));
            chk({sel, rd_d & sel}, {8'h01 << (j + 3), 8'h00});
            rd();
            chk({15'h0, flag}, 16'h0000);
        end
        // Channel 6 still selected while the port is rewritten
        @(negedge clk);
        port_wr = 1'b1;
        out_d = 8'hFF;
        dir_d = 8'hFF;
        @(negedge clk);
        port_wr = 1'b0;
        @(negedge clk);
        chk({pin_oe_n, pin_out}, 16'h40BF);
        chk({8'h00, rd_d}, 16'h00BF);
        ctl(3'h2, 1'b0, 1'b1, 2'h0);
        wait_for(1'b1);
        chk({14'h0, flag, irq_en}, 16'h0001);
        ctl(3'h2, 1'b0, 1'b1, 2'h0);
        chk({15'h0, irq}, 16'h0000);
        wait_for(1'b1);
        chk({rhi, rlo}, place(2, 2'h0));
        rd();
        chk({15'h0, irq}, 16'h0000);
        ctl(3'h7, 1'b1, 1'b0, 2'h0);
        chk({15'h0, flag}, 16'h0000);
        wait_for(1'b0);
        rd();
        wait_for(1'b0);
        chk({rhi, rlo}, place(7, 2'h0));
        // Reset with the flag up and the loop still running
        reset_pulse();
        chk({13'h0, flag, irq_en, irq}, 16'h0000);
        ctl(3'h1, 1'b0, 1'b1, 2'h0);
        wait_for(1'b1);
        reset_pulse();
        chk({13'h0, flag, irq_en, irq}, 16'h0000);
        // One trial every four clocks: no result after 20 clocks
        @(negedge clk);
        clk_wr = 1'b1;
        clk_div = 2'h2;
        @(negedge clk);
        clk_wr = 1'b0;
        ctl(3'h5, 1'b0, 1'b0, 2'h0);
        repeat (20) @(negedge clk);
        chk({15'h0, flag}, 16'h0000);
        wait_for(1'b0);
        chk({rhi, rlo}, place(5, 2'h0));
        // Converter switched off: every pin back under port control
        ctrl_on = 1'b0;
        ctl(3'h4, 1'b0, 1'b0, 2'h0);
        chk({sel, pin_oe_n}, 16'h00FF);
        tally_and_finish();
    end
endmodule // tb_scc_converter_control
bind scc_converter_control scc_converter_control_monitor mon_u (.clk, .rstn,
    .ctrl_wr, .result_rd, .port_dir_wr, .port_dir_data, .pin_out, .pin_oe_n,
    .port_rd_data, .selected_analog_input, .conversion_done_flag,
    .conversion_irq_enable, .conversion_irq, .converter_busy);
